// ---- design/mci_pkg.sv ----
// constants, types and states shared by the monitor command interface
package mci_pkg;

  // ****************************************************************
  // bus addressing
  // ****************************************************************
  localparam logic [4:0] MCI_ADDR_BASE = 5'h0b;
  localparam logic [1:0] MCI_SEL_ALERT_EN = 2'h1;
  localparam logic [1:0] MCI_SEL_THRESH = 2'h2;
  localparam logic [1:0] MCI_SEL_CONTROL = 2'h3;
  localparam logic [1:0] MCI_SEL_NONE = 2'h0;
  localparam logic [4:0] MCI_SEL_PAD_ZERO = 5'h00;
  localparam logic [3:0] MCI_BYTE_BITS = 4'h8;
  localparam logic [1:0] MCI_LAST_WR_BYTE = 2'h1;
  localparam logic [1:0] MCI_LAST_RD_BYTE = 2'h3;

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [7:0] MCI_THRESH_RESET = 8'hff;
  localparam logic [2:0] MCI_RUN_TRIP = 3'h4;
  localparam logic [2:0] MCI_RUN_RECENT = 3'h3;

  // ****************************************************************
  // field layouts
  // ****************************************************************
  typedef struct packed {
    logic status_read;
    logic unused;
    logic divider_select;
    logic amp_once;
    logic amp_continuous;
    logic volt_once;
    logic volt_continuous;
  } mci_cmd_t;

  typedef struct packed {
    logic is_ext;
    mci_cmd_t cmd;
  } mci_first_t;

  typedef struct packed {
    logic is_ext;
    logic [4:0] pad;
    logic [1:0] sel;
  } mci_sel_t;

  typedef struct packed {
    logic [2:0] pad;
    logic clear;
    logic off_alert_enable;
    logic comparator_latch_enable;
    logic four_sample_trip_enable;
    logic single_sample_trip_enable;
  } mci_alert_en_t;

  localparam mci_alert_en_t MCI_ALERT_EN_RESET = 8'h04;

  typedef struct packed {
    logic [1:0] pad;
    logic off_alert;
    logic off_status;
    logic comparator_alert_flag;
    logic overcurrent;
    logic conv_alert;
    logic recent_trip;
  } mci_status_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [3:0] lo;
  } mci_code_t;

  typedef struct packed {
    logic is_ext;
    mci_sel_t sel;
    logic [7:0] data;
  } mci_wr_t;

  typedef struct packed {
    logic nack;
    logic [23:0] bytes;
  } mci_img_t;

  typedef enum logic [2:0] {
    MCI_IDLE = 3'b000,
    MCI_ADDR = 3'b001,
    MCI_ADDR_ACK = 3'b010,
    MCI_WRITE = 3'b011,
    MCI_WRITE_ACK = 3'b100,
    MCI_READ = 3'b101,
    MCI_READ_ACK = 3'b110
  } mci_state_t;

endpackage : mci_pkg

// ---- design/mci_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module mci_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule : mci_sync
`default_nettype wire

// ---- design/mci_top.sv ----
// serial slave command interpreter of the current and voltage monitor
`timescale 1ns/1ps
`default_nettype none
module mci_top (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_link_clock,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic [1:0] i_addr_strap,
  input wire logic i_overcurrent,
  input wire logic i_timer_trip,
  input wire logic i_conv_done,
  input wire logic i_conv_is_amp,
  input wire mci_pkg::mci_code_t i_conv_code,
  output logic o_volt_continuous,
  output logic o_amp_continuous,
  output logic o_volt_start,
  output logic o_amp_start,
  output logic o_divider_select,
  output logic o_alert,
  output logic o_alert_out,
  output logic o_alert_oe_n
);
  import mci_pkg::*;

  // ****************************************************************
  // link side: pin sampling
  // ****************************************************************
  logic [3:0] pins_s;
  logic scl_s, sda_s, scl_q, sda_q;
  logic [1:0] strap_s;
  mci_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q, tx_q;
  logic [1:0] idx_q, strap_q;
  logic sda_low_q, wr_tgl_q, img_ack_q, img_req_s;
  mci_first_t first_q;
  mci_wr_t wr_q;
  mci_img_t img_q, img_hold_q;
  logic img_req_q;

  mci_sync #(.W(4)) u_pin_sync (
    .i_clock(i_link_clock),
    .i_nrst(i_nrst),
    .i_d({i_scl, i_sda, i_addr_strap}),
    .o_q(pins_s)
  );
  mci_sync #(.W(1)) u_req_sync (
    .i_clock(i_link_clock),
    .i_nrst(i_nrst),
    .i_d(img_req_q),
    .o_q(img_req_s)
  );
  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign strap_s = pins_s[1:0];

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;
  wire byte_end = scl_fall & (cnt_q == MCI_BYTE_BITS);
  wire addr_hit = (sr_q[7:1] == {MCI_ADDR_BASE, strap_q});
  wire is_read = sr_q[0];
  wire [7:0] rd_byte = (idx_q == 2'h0) ? img_q.bytes[23:16] :
                       (idx_q == 2'h1) ? img_q.bytes[15:8] :
                       (idx_q == 2'h2) ? img_q.bytes[7:0] : 8'h00;
  wire img_new = img_req_s ^ img_ack_q;
  wire img_take = img_new & ((state_q == MCI_IDLE) | (state_q == MCI_ADDR));
  wire first_ext = sr_q[7];

  always_ff @(posedge i_link_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      strap_q <= 2'h0;
      img_q <= '0;
      img_ack_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      // static strap re-read while idle: no capture before the sync fills
      if (state_q == MCI_IDLE) begin
        strap_q <= strap_s;
      end
      if (img_take) begin
        img_q <= img_hold_q;
        img_ack_q <= ~img_ack_q;
      end
    end
  end

  // ****************************************************************
  // link side: byte engine
  // ****************************************************************
  always_ff @(posedge i_link_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= MCI_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 2'h0;
      first_q <= '0;
      sda_low_q <= 1'b0;
      wr_q <= '0;
      wr_tgl_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= MCI_IDLE;
      sda_low_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= MCI_ADDR;
      cnt_q <= 4'h0;
      idx_q <= 2'h0;
      sda_low_q <= 1'b0;
    end else begin
      case (state_q)
        MCI_ADDR, MCI_WRITE: begin
          if (scl_rise) begin
            sr_q <= {sr_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_end && state_q == MCI_ADDR) begin
            // a pending single conversion refuses the read
            if (addr_hit && !(is_read && img_q.nack)) begin
              sda_low_q <= 1'b1;
              state_q <= MCI_ADDR_ACK;
            end else begin
              state_q <= MCI_IDLE;
            end
          end else if (byte_end) begin
            sda_low_q <= (idx_q <= MCI_LAST_WR_BYTE);
            state_q <= MCI_WRITE_ACK;
            if (idx_q == 2'h0) begin
              first_q <= sr_q;
              if (!first_ext) begin
                wr_q <= {1'b0, 8'h00, sr_q};
                wr_tgl_q <= ~wr_tgl_q;
              end
            end else if (idx_q == MCI_LAST_WR_BYTE && first_q.is_ext) begin
              wr_q <= {1'b1, first_q, sr_q};
              wr_tgl_q <= ~wr_tgl_q;
            end
          end
        end
        MCI_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (is_read) begin
              tx_q <= {rd_byte[6:0], 1'b0};
              sda_low_q <= ~rd_byte[7];
              state_q <= MCI_READ;
            end else begin
              sda_low_q <= 1'b0;
              state_q <= MCI_WRITE;
            end
          end
        end
        MCI_WRITE_ACK: begin
          if (scl_fall) begin
            sda_low_q <= 1'b0;
            cnt_q <= 4'h0;
            if (idx_q != MCI_LAST_RD_BYTE) begin
              idx_q <= idx_q + 2'h1;
            end
            state_q <= MCI_WRITE;
          end
        end
        MCI_READ: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_end) begin
            sda_low_q <= 1'b0;
            state_q <= MCI_READ_ACK;
          end else if (scl_fall) begin
            sda_low_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        MCI_READ_ACK: begin
          if (scl_rise && sda_s) begin
            state_q <= MCI_IDLE;
          end else if (scl_rise && idx_q != MCI_LAST_RD_BYTE) begin
            idx_q <= idx_q + 2'h1;
          end else if (scl_fall) begin
            cnt_q <= 4'h0;
            tx_q <= {rd_byte[6:0], 1'b0};
            sda_low_q <= ~rd_byte[7];
            state_q <= MCI_READ;
          end
        end
        default: begin
          state_q <= MCI_IDLE;
        end
      endcase
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = ~sda_low_q;

  a_addr_ack: assert property (@(posedge i_link_clock) disable iff (!i_nrst)
    state_q == MCI_ADDR && byte_end && addr_hit && !is_read && !bus_stop
    && !bus_start |=> sda_low_q && state_q == MCI_ADDR_ACK)
    else $error("addressed write not acknowledged");
  a_write_ack: assert property (@(posedge i_link_clock) disable iff (!i_nrst)
    state_q == MCI_WRITE && byte_end && idx_q == 2'h0 && !bus_stop
    && !bus_start |=> sda_low_q ##1 (sda_low_q || !scl_s || bus_stop
    || bus_start || state_q != MCI_WRITE_ACK))
    else $error("first written byte not acknowledged");

  // ****************************************************************
  // core side: register writes
  // ****************************************************************
  logic wr_tgl_s, wr_seen_q, oc_s, timer_s, img_ack_s;
  mci_cmd_t cmd_q;
  mci_alert_en_t alert_en_q;
  logic [7:0] thresh_q;
  logic software_off_q, clear_q;

  mci_sync #(.W(4)) u_core_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_d({wr_tgl_q, i_overcurrent, i_timer_trip, img_ack_q}),
    .o_q({wr_tgl_s, oc_s, timer_s, img_ack_s})
  );

  // the word stays still until the next toggle, so it is read directly
  wire wr_ev = wr_tgl_s ^ wr_seen_q;
  wire cmd_wr = wr_ev & ~wr_q.is_ext;
  wire sel_ok = (wr_q.sel.pad == MCI_SEL_PAD_ZERO) & wr_q.sel.is_ext
              & (wr_q.sel.sel != MCI_SEL_NONE);
  wire ext_wr = wr_ev & wr_q.is_ext & sel_ok;
  wire en_wr = ext_wr & (wr_q.sel.sel == MCI_SEL_ALERT_EN);
  wire th_wr = ext_wr & (wr_q.sel.sel == MCI_SEL_THRESH);
  wire ctl_wr = ext_wr & (wr_q.sel.sel == MCI_SEL_CONTROL);
  mci_cmd_t cmd_in;
  mci_alert_en_t en_in;
  assign cmd_in = wr_q.data[6:0];
  assign en_in = wr_q.data;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_seen_q <= 1'b0;
      cmd_q <= '0;
      alert_en_q <= MCI_ALERT_EN_RESET;
      thresh_q <= MCI_THRESH_RESET;
      software_off_q <= 1'b0;
      clear_q <= 1'b0;
    end else begin
      wr_seen_q <= wr_tgl_s;
      clear_q <= en_wr & en_in.clear;
      if (cmd_wr) begin
        cmd_q <= cmd_in;
      end
      if (en_wr) begin
        alert_en_q <= {3'h0, 1'b0, en_in[3:0]};
      end
      if (th_wr) begin
        thresh_q <= wr_q.data;
      end
      if (ctl_wr) begin
        software_off_q <= wr_q.data[0];
      end
    end
  end

  // ****************************************************************
  // core side: conversions and alerts
  // ****************************************************************
  mci_code_t volt_code_q, amp_code_q;
  logic volt_pend_q, amp_pend_q, volt_start_q, amp_start_q;
  logic [2:0] run_q;
  mci_status_t status_w;
  logic conv_alert_q, comp_alert_q, off_alert_q, alert_q;

  wire volt_done = i_conv_done & ~i_conv_is_amp;
  wire amp_done = i_conv_done & i_conv_is_amp;
  wire above = amp_done & (i_conv_code.hi > thresh_q);
  wire trip_one = above & alert_en_q.single_sample_trip_enable;
  wire trip_four = above & alert_en_q.four_sample_trip_enable
                 & (run_q == MCI_RUN_TRIP - 3'h1);
  wire comp_set = alert_en_q.comparator_latch_enable & oc_s & timer_s;
  wire off_set = alert_en_q.off_alert_enable & software_off_q;
  wire force_off = alert_en_q.off_alert_enable & software_off_q;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      volt_code_q <= '0;
      amp_code_q <= '0;
      volt_pend_q <= 1'b0;
      amp_pend_q <= 1'b0;
      volt_start_q <= 1'b0;
      amp_start_q <= 1'b0;
      run_q <= 3'h0;
    end else begin
      volt_start_q <= cmd_wr & cmd_in.volt_once;
      amp_start_q <= cmd_wr & cmd_in.amp_once;
      volt_pend_q <= (cmd_wr & cmd_in.volt_once) | (volt_pend_q & ~volt_done);
      amp_pend_q <= (cmd_wr & cmd_in.amp_once) | (amp_pend_q & ~amp_done);
      if (cmd_wr) begin
        volt_code_q <= '0;
        amp_code_q <= '0;
      end else begin
        if (volt_done) begin
          volt_code_q <= i_conv_code;
        end
        if (amp_done) begin
          amp_code_q <= i_conv_code;
        end
      end
      if (amp_done) begin
        run_q <= !above ? 3'h0 :
                 (run_q == MCI_RUN_TRIP) ? run_q : run_q + 3'h1;
      end
    end
  end

  // set beats clear so a standing cause re-arms the flag at once
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_alert_q <= 1'b0;
      comp_alert_q <= 1'b0;
      off_alert_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      conv_alert_q <= trip_one | trip_four | (conv_alert_q & ~clear_q);
      comp_alert_q <= comp_set | (comp_alert_q & ~clear_q);
      off_alert_q <= off_set | (off_alert_q & ~clear_q);
      alert_q <= (conv_alert_q | comp_alert_q) & ~force_off;
    end
  end

  assign status_w = {2'h0, off_alert_q, software_off_q, comp_alert_q, oc_s,
                     conv_alert_q, (run_q >= MCI_RUN_RECENT)};
  assign o_volt_continuous = cmd_q.volt_continuous;
  assign o_amp_continuous = cmd_q.amp_continuous;
  assign o_volt_start = volt_start_q;
  assign o_amp_start = amp_start_q;
  assign o_divider_select = cmd_q.divider_select;
  assign o_alert = alert_q;
  assign o_alert_out = 1'b0;
  assign o_alert_oe_n = alert_q;

  // ****************************************************************
  // core side: read image handed to the link
  // ****************************************************************
  wire use_v = cmd_q.volt_continuous | cmd_q.volt_once;
  wire use_a = cmd_q.amp_continuous | cmd_q.amp_once;
  wire [23:0] bytes_w =
    cmd_q.status_read ? {status_w, 16'h0000} :
    (use_v & use_a) ? {volt_code_q.hi, amp_code_q.hi,
                       volt_code_q.lo, amp_code_q.lo} :
    use_a ? {amp_code_q.hi, amp_code_q.lo, 4'h0, 8'h00} :
            {volt_code_q.hi, volt_code_q.lo, 4'h0, 8'h00};
  mci_img_t img_w;
  assign img_w = {volt_pend_q | amp_pend_q, bytes_w};
  wire img_busy = img_req_q ^ img_ack_s;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      img_hold_q <= '0;
      img_req_q <= 1'b0;
    end else if (!img_busy && img_w != img_hold_q) begin
      img_hold_q <= img_w;
      img_req_q <= ~img_req_q;
    end
  end

  // ****************************************************************
  // core side checks
  // ****************************************************************
  sequence s_once_cmd;
    cmd_wr && cmd_in.volt_once;
  endsequence
  a_once_pulse: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_once_cmd |=> o_volt_start ##1 !o_volt_start)
    else $error("single voltage start not one pulse");
  a_pend_refuse: assert property (@(posedge i_clock) disable iff (!i_nrst)
    cmd_wr && cmd_in.amp_once |=> img_w.nack [*2])
    else $error("pending current read not refused");
  a_divider_sel: assert property (@(posedge i_clock) disable iff (!i_nrst)
    cmd_wr |=> o_divider_select == $past(cmd_in.divider_select))
    else $error("divider select not taken from command");
  a_clear_self: assert property (@(posedge i_clock) disable iff (!i_nrst)
    clear_q && !trip_one && !trip_four |=> !conv_alert_q ##0 !clear_q)
    else $error("clear did not drop flag or self-clear");
  a_set_wins: assert property (@(posedge i_clock) disable iff (!i_nrst)
    comp_set |=> comp_alert_q)
    else $error("comparator alert lost against clear");
  a_single_trip: assert property (@(posedge i_clock) disable iff (!i_nrst)
    trip_one |=> conv_alert_q ##1 (alert_q || force_off))
    else $error("single sample trip missed");
  a_software_off_force: assert property (@(posedge i_clock) disable iff (!i_nrst)
    force_off ##1 force_off |-> !alert_q && off_alert_q)
    else $error("software off did not force alert low");
  a_bad_select: assert property (@(posedge i_clock) disable iff (!i_nrst)
    wr_ev && wr_q.is_ext && !sel_ok |=> $stable(thresh_q)
    && $stable(software_off_q) && $stable(alert_en_q[3:0]))
    else $error("bad select changed a register");
endmodule : mci_top
`default_nettype wire

// ---- dv/mci_master.sv ----
// bit-banged serial bus master standing on the device pins
`timescale 1ns/1ps
`default_nettype none
module mci_master (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  // ****************************************************************
  // bus timing
  // ****************************************************************
  // quarter bit; half period far above the 3-flop pin sampling delay
  localparam int QTR = 200;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // released data goes to the pull-up level, never the last bit
  task automatic start();
    #QTR o_sda_low = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b1;
    #QTR o_scl = 1'b0;
  endtask : start
  task automatic stop();
    #QTR o_sda_low = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b0;
    #QTR;
  endtask : stop
  task automatic xbit(input logic b, output logic r);
    #QTR o_sda_low = ~b;
    #QTR o_scl = 1'b1;
    #QTR r = i_sda;
    #QTR o_scl = 1'b0;
  endtask : xbit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(last, r);
  endtask : rbyte
endmodule : mci_master
`default_nettype wire

// ---- dv/mci_top_test.sv ----
// self-checking bench of the monitor command interpreter
`timescale 1ns/1ps
`default_nettype none
module mci_top_test;
  import mci_pkg::*;
  logic i_clock = 1'b0;
  logic i_link_clock = 1'b0;
  logic i_nrst, i_overcurrent, i_timer_trip, i_conv_done, i_conv_is_amp;
  logic scl, sda_low, sda, sda_oe_n, alert, vcont, acont, vstart, astart;
  logic dsel, sda_out, alert_out, alert_oe_n;
  logic [1:0] strap;
  logic [2:0] ak;
  logic [7:0] th;
  logic [23:0] rd;
  logic [31:0] lfsr = 32'h5993;
  mci_code_t code, vc, ic;
  int num_errors = 0;
  int total_checks = 0;
  int vs_cnt = 0;
  int as_cnt = 0;

  always #4 i_clock = ~i_clock;
  initial begin
    #3.3;
    forever #24 i_link_clock = ~i_link_clock;
  end
  // open-drain data wire with pull-up
  assign sda = (sda_low || !sda_oe_n) ? 1'b0 : 1'b1;
  always @(posedge i_clock) begin
    vs_cnt <= vs_cnt + (vstart === 1'b1);
    as_cnt <= as_cnt + (astart === 1'b1);
  end

  mci_top u_mci_top (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_link_clock(i_link_clock), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_addr_strap(strap),
    .i_overcurrent(i_overcurrent), .i_timer_trip(i_timer_trip),
    .i_conv_done(i_conv_done), .i_conv_is_amp(i_conv_is_amp),
    .i_conv_code(code), .o_volt_continuous(vcont),
    .o_amp_continuous(acont), .o_volt_start(vstart), .o_amp_start(astart),
    .o_divider_select(dsel), .o_alert(alert), .o_alert_out(alert_out),
    .o_alert_oe_n(alert_oe_n));
  mci_master u_mci_master (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  // m: 3 both channels, 1 voltage only, 2 current only
  function automatic logic [23:0] img(input mci_code_t v, i, input int m);
    case (m)
      3: return {v.hi, i.hi, v.lo, i.lo};
      1: return {8'h00, v.hi, v.lo, 4'h0};
      default: return {8'h00, i.hi, i.lo, 4'h0};
    endcase
  endfunction : img
  task automatic check(input logic [23:0] seen, exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : check
  task automatic chk1(input logic s, e, input string m);
    check({23'h0, s}, {23'h0, e}, m);
  endtask : chk1
  // wrong address: every byte refused, so nothing is acked
  task automatic wr(input logic [1:0] a, input logic [7:0] b0, b1,
                    input int n);
    logic [2:0] e;
    ak = 3'h0;
    e = (a == strap) ? 3'((1 << (n + 1)) - 1) : 3'h0;
    u_mci_master.start();
    u_mci_master.wbyte({MCI_ADDR_BASE, a, 1'b0}, ak[0]);
    if (n > 0) u_mci_master.wbyte(b0, ak[1]);
    if (n > 1) u_mci_master.wbyte(b1, ak[2]);
    u_mci_master.stop();
    #1000;
    check({21'h0, ak}, {21'h0, e}, "write acks");
  endtask : wr
  task automatic rdn(input int n, input logic ok, input logic [23:0] exp);
    logic a;
    logic [7:0] b;
    rd = 24'h00_0000;
    u_mci_master.start();
    u_mci_master.wbyte({MCI_ADDR_BASE, strap, 1'b1}, a);
    chk1(a, ok, "read address ack");
    for (int i = 0; i < n && a; i++) begin
      u_mci_master.rbyte(i == n - 1, b);
      rd = {rd[15:0], b};
    end
    u_mci_master.stop();
    #1000;
    if (ok) check(rd, exp, "read data");
  endtask : rdn
  task automatic conv(input logic amp, input mci_code_t c);
    @(negedge i_clock);
    i_conv_done = 1'b1;
    i_conv_is_amp = amp;
    code = c;
    @(negedge i_clock);
    i_conv_done = 1'b0;
    #1000;
  endtask : conv
  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    #700_000;
    num_errors++;
    conclude();
  end
  initial begin
    i_nrst = 1'b0;
    i_overcurrent = 1'b0;
    i_timer_trip = 1'b0;
    i_conv_done = 1'b0;
    i_conv_is_amp = 1'b0;
    code = 12'h000;
    lfsr = step(lfsr);
    strap = lfsr[1:0];
    // held over both clocks, the link one being the slower
    repeat (3) @(posedge i_link_clock);
    @(negedge i_clock);
    check({16'h0, sda_out, alert_out, alert_oe_n, alert, dsel, vcont, acont,
           sda_oe_n}, 24'h1, "reset");
    i_nrst = 1'b1;
    #1000;
    for (int k = 0; k < 4; k++) wr(k[1:0], 8'h00, 8'h00, 0);
    i_overcurrent = 1'b1;
    i_timer_trip = 1'b1;
    repeat (8) @(negedge i_clock);
    chk1(alert, 1'b1, "latched alert");
    chk1(alert_oe_n, 1'b1, "alert pin released");
    wr(strap, 8'h81, 8'h14, 2);
    chk1(alert, 1'b1, "clear with cause kept");
    i_overcurrent = 1'b0;
    i_timer_trip = 1'b0;
    repeat (8) @(negedge i_clock);
    chk1(alert, 1'b1, "alert stays latched");
    wr(strap, 8'h81, 8'h10, 2);
    chk1(alert, 1'b0, "alert cleared");
    for (int k = 0; k < 3; k++) begin
      lfsr = step(lfsr);
      th = (k == 0) ? 8'h15 : lfsr[7:0] & 8'h15;
      wr(strap, th, 8'h00, 1);
      check({21'h0, dsel, acont, vcont}, {21'h0, th[4], th[2], th[0]},
            "command levels");
    end
    wr(strap, 8'h05, 8'h00, 1);
    rdn(3, 1'b1, 24'h00_0000);
    lfsr = step(lfsr);
    vc = lfsr[11:0];
    ic = lfsr[23:12];
    conv(1'b0, vc);
    conv(1'b1, ic);
    rdn(3, 1'b1, img(vc, ic, 3));
    wr(strap, 8'h12, 8'h00, 1);
    chk1(dsel, 1'b1, "divider");
    chk1(vs_cnt == 1, 1'b1, "volt start");
    rdn(2, 1'b0, 24'h00_0000);
    conv(1'b0, vc);
    rdn(2, 1'b1, img(vc, ic, 1));
    wr(strap, 8'h08, 8'h00, 1);
    chk1(as_cnt == 1, 1'b1, "amp start");
    rdn(2, 1'b0, 24'h00_0000);
    conv(1'b1, ic);
    rdn(2, 1'b1, img(vc, ic, 2));
    lfsr = step(lfsr);
    th = {1'b0, lfsr[6:0]};
    wr(strap, 8'h82, th, 2);
    wr(strap, 8'h81, 8'h01, 2);
    // malformed selects must leave threshold and enables alone
    wr(strap, 8'h86, 8'h00, 2);
    wr(strap, 8'h85, 8'h00, 2);
    wr(strap, 8'h80, 8'h00, 2);
    wr(strap, 8'h04, 8'h00, 1);
    conv(1'b1, {th, 4'hf});
    chk1(alert, 1'b0, "equal is not above");
    conv(1'b1, {th + 8'h01, 4'h0});
    chk1(alert, 1'b1, "single trip");
    wr(strap, 8'h81, 8'h12, 2);
    chk1(alert, 1'b0, "trip cleared");
    conv(1'b1, {th, 4'h0});
    for (int k = 1; k <= 4; k++) begin
      conv(1'b1, {th + 8'h01, 4'h0});
      chk1(alert, k == 4, "four samples");
    end
    conv(1'b1, 12'h000);
    // off enable alone keeps the four-sample alert standing
    wr(strap, 8'h81, 8'h08, 2);
    chk1(alert, 1'b1, "alert before software off");
    wr(strap, 8'h83, 8'h01, 2);
    chk1(alert, 1'b0, "software off");
    wr(strap, 8'h40, 8'h00, 1);
    rdn(3, 1'b1, 24'h32_0000);
    conclude();
  end
endmodule : mci_top_test
`default_nettype wire
